/* File: src/fbr_flash_end.sv */
// Flash end: configuration register, command decode and burst read timing
//
// Implementation choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - Latency affects synchronous bursts only
// - Latency counted from start edge to data
// - Start and latch address on first ADV
// - Latency equals code plus two clocks
// - Host keeps clock edge bit at one
// - Each burst word held one clock
// - Hardware reset ends burst, forces async
// - Register reached only through commands
// - Writes ignored while program or erase runs
// - Register reads zero upper sixteen bits
// - Register read latches bank; other bank array
// - Read mode bit zero enables bursts
// - Sleep bit one disables automatic sleep
// - Timing bit one flags one word early
// - Burst order is always linear wrap
// - Host writes zero to reserved bits
// - Length code selects 2, 4, 8 or none
// - Reset value is the documented default
// - Burst wraps in aligned group
// - Chip enable high exits burst, floats
// - Indicator high, one-clock low, float otherwise
module fbr_flash_end
    import fbr_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    fbr_link_if.flash link,
    input wire logic algo_busy,
    input wire logic [31:0] arr_rd_data,
    output logic [18:0] arr_rd_addr,
    output logic [15:0] cr_value,
    output logic sync_mode,
    output logic auto_sleep_en,
    output logic burst_active
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ASYNC = 4'b0010,
        ST_WAIT = 4'b0100,
        ST_DATA = 4'b1000
    } fbr_dev_state_e;

    fbr_dev_state_e state_reg;
    fbr_dev_state_e state_next;
    logic [4:0] lat_cnt_reg;
    logic [4:0] lat_cnt_next;
    logic [15:0] cr_reg;
    logic crmode_reg;
    logic crbank_reg;
    logic cr_hit_reg;
    logic [15:0] hi_reg;
    logic adv_low_reg;
    logic we_low_reg;
    logic [31:0] dq_reg;
    logic dq_oe_reg;
    logic ind_reg;
    logic ind_oe_reg;
    logic sync_reg;
    logic sleep_reg;
    logic burst_reg;
    logic [2:0] word_lo;
    logic seq_flag;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire hw_rst = ~reset_n | ~link.rst_n;
    wire sel = ~link.ce_n;
    // A start is the first edge that sees ADV low; the previous edge saw it high or chip enable high
    wire adv_start = sel & ~link.adv_n & ~adv_low_reg;
    wire [3:0] words = fbr_burst_words(cr_reg[CR_BL_MSB:0]);
    // Order and hold bits have one legal value, so they steer nothing
    wire burst_on = ~cr_reg[CR_RM] & (words != 4'h0);
    wire [4:0] lat = {1'b0, cr_reg[CR_LAT_MSB:CR_LAT_LSB]} + LAT_OFFSET;
    wire hit_now = crmode_reg & (link.addr[BANK_BIT] == crbank_reg);
    wire go_burst = burst_on & ~hit_now;
    wire lat_done = (state_reg == ST_WAIT) & (lat_cnt_reg == lat);
    wire load_beat = sel & ~adv_start & (lat_done | (state_reg == ST_DATA));
    wire [31:0] cr_word = {16'h0000, cr_reg};
    wire [31:0] async_word = cr_hit_reg ? cr_word : arr_rd_data;
    wire [31:0] dq_next = load_beat ? arr_rd_data : ((state_reg == ST_ASYNC) ? async_word : dq_reg);
    wire drive_data = (state_next == ST_ASYNC) | (state_next == ST_DATA);
    wire drive_ind = (state_next == ST_WAIT) | (state_next == ST_DATA);
    wire out_en = sel & ~link.oe_n;
    wire ind_next = load_beat ? ~seq_flag : 1'b1;

    // ----------------------------------------------------------------
    // Commands
    // ----------------------------------------------------------------
    wire wr_first = sel & ~link.we_n & ~we_low_reg;
    wire [7:0] cmd = link.dq[31:CMD_LSB];
    wire cr_wr = wr_first & (cmd == CMD_CR_WRITE) & ~algo_busy;
    wire cr_rd_cmd = wr_first & (cmd == CMD_CR_READ);
    wire arr_cmd = wr_first & (cmd == CMD_READ_ARRAY);
    wire [15:0] cr_next = cr_wr ? link.dq[15:0] : cr_reg;
    wire crmode_next = cr_rd_cmd | (crmode_reg & ~arr_cmd);
    wire crbank_next = cr_rd_cmd ? link.addr[BANK_BIT] : crbank_reg;

    // ----------------------------------------------------------------
    // Burst control
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        lat_cnt_next = lat_cnt_reg;
        if (!sel) begin
            state_next = ST_IDLE;
        end else if (adv_start) begin
            // A new ADV discards whatever burst was running
            lat_cnt_next = 5'h01;
            state_next = go_burst ? ST_WAIT : ST_ASYNC;
        end else begin
            case (state_reg)
                ST_WAIT: begin
                    if (lat_done) begin
                        state_next = ST_DATA;
                    end else begin
                        lat_cnt_next = lat_cnt_reg + 5'h01;
                    end
                end
                ST_IDLE, ST_ASYNC, ST_DATA: begin
                    state_next = state_reg;
                end
                default: begin
                    state_next = ST_IDLE;
                end
            endcase
        end
    end

    fbr_burst_seq u_seq (
        .core_clk(core_clk),
        .clear(hw_rst),
        .load(adv_start),
        .start_lo(link.addr[2:0]),
        .step(load_beat),
        .words(words),
        .early(cr_reg[CR_WC]),
        .word_lo(word_lo),
        .last_flag(seq_flag)
    );

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (hw_rst) begin
            state_reg <= ST_IDLE;
            lat_cnt_reg <= 5'h01;
            cr_reg <= CR_RESET;
            crmode_reg <= 1'b0;
            crbank_reg <= 1'b0;
            cr_hit_reg <= 1'b0;
            hi_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            lat_cnt_reg <= lat_cnt_next;
            cr_reg <= cr_next;
            crmode_reg <= crmode_next;
            crbank_reg <= crbank_next;
            if (adv_start) begin
                cr_hit_reg <= hit_now;
                hi_reg <= link.addr[18:3];
            end
        end
    end

    // Pin-side outputs; floating while reset is held
    always_ff @(posedge core_clk) begin
        if (hw_rst) begin
            adv_low_reg <= 1'b0;
            we_low_reg <= 1'b0;
            dq_reg <= 32'h0000_0000;
            dq_oe_reg <= 1'b0;
            ind_reg <= 1'b1;
            ind_oe_reg <= 1'b0;
        end else begin
            adv_low_reg <= sel & ~link.adv_n;
            we_low_reg <= sel & ~link.we_n;
            dq_reg <= dq_next;
            dq_oe_reg <= out_en & drive_data;
            ind_reg <= ind_next;
            ind_oe_reg <= out_en & drive_ind;
        end
    end

    // User-side status
    always_ff @(posedge core_clk) begin
        if (hw_rst) begin
            sync_reg <= 1'b0;
            sleep_reg <= 1'b1;
            burst_reg <= 1'b0;
        end else begin
            sync_reg <= burst_on;
            sleep_reg <= ~cr_reg[CR_ASD];
            burst_reg <= drive_ind & sel;
        end
    end

    assign arr_rd_addr = {hi_reg, word_lo};
    assign cr_value = cr_reg;
    assign sync_mode = sync_reg;
    assign auto_sleep_en = sleep_reg;
    assign burst_active = burst_reg;
    assign link.dev_dq_o = dq_reg;
    assign link.dev_dq_oe = dq_oe_reg;
    assign link.ind_n_o = ind_reg;
    assign link.ind_n_oe = ind_oe_reg;
endmodule : fbr_flash_end

/* File: src/fbr_pkg.sv */
// Shared constants and helpers for the flash burst read configuration link
package fbr_pkg;
    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 19;
    localparam int DATA_W = 32;
    localparam int CR_W = 16;
    localparam int BANK_BIT = 18;
    localparam int MAX_BEATS = 8;
    // ----------------------------------------------------------------
    // Configuration register fields
    // ----------------------------------------------------------------
    localparam int CR_RM = 15;
    localparam int CR_ASD = 14;
    localparam int CR_LAT_MSB = 13;
    localparam int CR_LAT_LSB = 10;
    localparam int CR_DOC = 9;
    localparam int CR_WC = 8;
    localparam int CR_BS = 7;
    localparam int CR_CC = 6;
    localparam int CR_RSV_MSB = 5;
    localparam int CR_RSV_LSB = 3;
    localparam int CR_BL_MSB = 2;
    localparam logic [15:0] CR_RESET = 16'h9CC4;
    localparam logic [4:0] LAT_OFFSET = 5'h02;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    // ----------------------------------------------------------------
    // Command codes on data bits 31:24 of a write cycle
    // ----------------------------------------------------------------
    localparam int CMD_LSB = 24;
    localparam logic [7:0] CMD_CR_WRITE = 8'hC0;
    localparam logic [7:0] CMD_CR_READ = 8'hC6;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hF0;
    // ----------------------------------------------------------------
    // Controller register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_LAT = 8'h10;
    localparam logic [7:0] REG_BEATS = 8'h14;
    localparam logic [2:0] REG_RDATA_PAGE = 3'h1;
    localparam int CTRL_GO = 0;
    localparam int CTRL_OP_LSB = 1;
    localparam int CTRL_RST = 3;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [4:0] HOST_LAT_RESET = 5'h09;
    localparam logic [3:0] HOST_BEATS_RESET = 4'h1;

    // Burst words for a length code; zero means bursts disabled
    function automatic logic [3:0] fbr_burst_words(input logic [2:0] code);
        case (code)
            BL_2: fbr_burst_words = 4'h2;
            BL_4: fbr_burst_words = 4'h4;
            BL_8: fbr_burst_words = 4'h8;
            default: fbr_burst_words = 4'h0;
        endcase
    endfunction : fbr_burst_words
endpackage : fbr_pkg

/* File: src/fbr_link_if.sv */
// Pin-level link between the burst flash end and its controller
`timescale 1ns/1ps
interface fbr_link_if;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic adv_n;
    logic rst_n;
    logic [18:0] addr;
    logic [31:0] host_dq_o;
    logic host_dq_oe;
    logic [31:0] dev_dq_o;
    logic dev_dq_oe;
    logic ind_n_o;
    logic ind_n_oe;
    logic [31:0] dq;
    logic ind_n;
    // Undriven lines read as pulled high
    assign dq = dev_dq_oe ? dev_dq_o : (host_dq_oe ? host_dq_o : 32'hFFFF_FFFF);
    assign ind_n = ind_n_oe ? ind_n_o : 1'b1;
    modport flash (input ce_n, oe_n, we_n, adv_n, rst_n, addr, dq,
                   output dev_dq_o, dev_dq_oe, ind_n_o, ind_n_oe);
    modport ctrl (output ce_n, oe_n, we_n, adv_n, rst_n, addr, host_dq_o, host_dq_oe,
                  input dq, ind_n);
endinterface : fbr_link_if

/* File: src/fbr_burst_seq.sv */
// Linear wrap-around word sequencer with end-of-burst flag
`timescale 1ns/1ps
module fbr_burst_seq
    import fbr_pkg::*;
(
    input wire logic core_clk,
    input wire logic clear,
    input wire logic load,
    input wire logic [2:0] start_lo,
    input wire logic step,
    input wire logic [3:0] words,
    input wire logic early,
    output logic [2:0] word_lo,
    output logic last_flag
);
    logic [2:0] lo_reg;
    logic [2:0] beat_reg;
    wire [3:0] mask4 = words - 4'h1;
    wire [2:0] mask = (words == 4'h0) ? 3'h0 : mask4[2:0];
    wire [2:0] lo_inc = lo_reg + 3'h1;
    wire [2:0] beat_inc = beat_reg + 3'h1;
    // Wrapping inside the aligned group returns to the start word by itself
    wire [2:0] lo_next = (lo_reg & ~mask) | (lo_inc & mask);
    wire [2:0] flag_beat = early ? (mask - 3'h1) : mask;

    assign word_lo = lo_reg;
    assign last_flag = (beat_reg == flag_beat);

    always_ff @(posedge core_clk) begin
        if (clear) begin
            lo_reg <= 3'h0;
            beat_reg <= 3'h0;
        end else if (load) begin
            lo_reg <= start_lo;
            beat_reg <= 3'h0;
        end else if (step) begin
            lo_reg <= lo_next;
            beat_reg <= beat_inc & mask;
        end
    end
endmodule : fbr_burst_seq

/* File: src/fbr_ctrl_end.sv */
// Controller end: Avalon-MM registers driving command writes and burst reads
`timescale 1ns/1ps
module fbr_ctrl_end
    import fbr_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    fbr_link_if.ctrl link
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        H_IDLE = 5'b00001,
        H_WR = 5'b00010,
        H_ADV = 5'b00100,
        H_WAIT = 5'b01000,
        H_CAP = 5'b10000
    } fbr_host_state_e;

    fbr_host_state_e st_reg;
    fbr_host_state_e st_next;
    logic [1:0] op_reg;
    logic rst_pin_reg;
    logic [18:0] addr_reg;
    logic [31:0] wdata_reg;
    logic [4:0] lat_reg;
    logic [3:0] beats_reg;
    logic [4:0] cnt_reg;
    logic [3:0] beat_reg;
    logic ind_seen_reg;
    logic [31:0] rdata_mem [MAX_BEATS];
    logic wait_reg;
    logic [31:0] rd_reg;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    wire acc = ~wait_reg;
    wire wr_ok = avs_write & acc;
    wire in_page = (avs_address[7:5] == REG_RDATA_PAGE);
    wire busy = (st_reg != H_IDLE);
    // A go while busy is dropped; software polls busy first
    wire go = wr_ok & (avs_address == REG_CTRL) & avs_writedata[CTRL_GO] & ~busy;
    wire [31:0] status_word = {30'h0000_0000, ind_seen_reg, busy};
    wire [31:0] ctrl_word = {28'h000_0000, rst_pin_reg, op_reg, 1'b0};
    wire [31:0] rd_mux =
        in_page ? rdata_mem[avs_address[4:2]] :
        (avs_address == REG_CTRL) ? ctrl_word :
        (avs_address == REG_ADDR) ? {13'h0000, addr_reg} :
        (avs_address == REG_WDATA) ? wdata_reg :
        (avs_address == REG_STATUS) ? status_word :
        (avs_address == REG_LAT) ? {27'h000_0000, lat_reg} :
        (avs_address == REG_BEATS) ? {28'h000_0000, beats_reg} : 32'h0000_0000;
    // Clock edge forced to one, reserved bits to zero on register writes
    wire is_cr_wr = (wdata_reg[31:CMD_LSB] == CMD_CR_WRITE);
    wire [31:0] safe_wdata = is_cr_wr ? ((wdata_reg | 32'h0000_0040) & 32'hFFFF_FFC7) : wdata_reg;

    // ----------------------------------------------------------------
    // Link sequencer
    // ----------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            H_IDLE: begin
                if (go) begin
                    st_next = (avs_writedata[2:1] == OP_WRITE) ? H_WR : H_ADV;
                end
            end
            H_WR: st_next = H_IDLE;
            H_ADV: st_next = H_WAIT;
            H_WAIT: st_next = (cnt_reg >= lat_reg) ? H_CAP : H_WAIT;
            H_CAP: st_next = (beat_reg + 4'h1 >= beats_reg) ? H_IDLE : H_CAP;
            default: st_next = H_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st_reg <= H_IDLE;
            cnt_reg <= 5'h01;
            beat_reg <= 4'h0;
            ind_seen_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= (st_reg == H_WAIT) ? cnt_reg + 5'h01 : 5'h01;
            beat_reg <= (st_reg == H_CAP) ? beat_reg + 4'h1 : 4'h0;
            if (st_reg == H_CAP && !link.ind_n) begin
                ind_seen_reg <= 1'b1;
            end else if (go) begin
                ind_seen_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (st_reg == H_CAP) begin
            rdata_mem[beat_reg[2:0]] <= link.dq;
        end
    end

    // ----------------------------------------------------------------
    // Registers and bus answer
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            op_reg <= OP_READ;
            rst_pin_reg <= 1'b0;
            addr_reg <= 19'h0_0000;
            wdata_reg <= 32'h0000_0000;
            lat_reg <= HOST_LAT_RESET;
            beats_reg <= HOST_BEATS_RESET;
            wait_reg <= 1'b1;
            rd_reg <= 32'h0000_0000;
        end else begin
            wait_reg <= ~(wait_reg & (avs_read | avs_write));
            if (wait_reg) begin
                rd_reg <= rd_mux;
            end
            if (wr_ok && avs_address == REG_CTRL) begin
                rst_pin_reg <= avs_writedata[CTRL_RST];
                if (go) begin
                    op_reg <= avs_writedata[2:1];
                end
            end
            if (wr_ok && avs_address == REG_ADDR) begin
                addr_reg <= avs_writedata[18:0];
            end
            if (wr_ok && avs_address == REG_WDATA) begin
                wdata_reg <= avs_writedata;
            end
            if (wr_ok && avs_address == REG_LAT) begin
                lat_reg <= avs_writedata[4:0];
            end
            if (wr_ok && avs_address == REG_BEATS) begin
                beats_reg <= avs_writedata[3:0];
            end
        end
    end

    // Pin drive registered from next state so pins meet the flash edge
    logic ce_n_reg;
    logic oe_n_reg;
    logic we_n_reg;
    logic adv_n_reg;
    logic dq_oe_reg;
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ce_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            adv_n_reg <= 1'b1;
            dq_oe_reg <= 1'b0;
        end else begin
            ce_n_reg <= (st_next == H_IDLE);
            oe_n_reg <= ~((st_next == H_ADV) | (st_next == H_WAIT) | (st_next == H_CAP));
            we_n_reg <= (st_next != H_WR);
            adv_n_reg <= (st_next != H_ADV);
            dq_oe_reg <= (st_next == H_WR);
        end
    end

    assign avs_waitrequest = wait_reg;
    assign avs_readdata = rd_reg;
    assign link.ce_n = ce_n_reg;
    assign link.oe_n = oe_n_reg;
    assign link.we_n = we_n_reg;
    assign link.adv_n = adv_n_reg;
    assign link.rst_n = ~rst_pin_reg;
    assign link.addr = addr_reg;
    assign link.host_dq_o = safe_wdata;
    assign link.host_dq_oe = dq_oe_reg;
endmodule : fbr_ctrl_end

/* File: dv/fbr_link_checker.sv */
// Assertions on the pin link between the flash end and the controller end
`timescale 1ns/1ps
module fbr_link_checker
    import fbr_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic adv_n,
    input wire logic rst_n,
    input wire logic [31:0] dq,
    input wire logic host_dq_oe,
    input wire logic dev_dq_oe,
    input wire logic ind_n_o,
    input wire logic ind_n_oe
);
    // ----------------------------------------------------------------
    // Link properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    AST_CE_EXIT: assert property (ce_n |=> !dev_dq_oe && !ind_n_oe)
        else $error("Flash outputs driven after chip enable went high");
    AST_OE_FLOAT: assert property (oe_n |=> !dev_dq_oe && !ind_n_oe)
        else $error("Flash outputs driven with output enable high");
    AST_RST_FLOAT: assert property (!rst_n |=> !dev_dq_oe && !ind_n_oe)
        else $error("Flash outputs driven during hardware reset");
    AST_IND_ONE_CLK: assert property (!ind_n_o && ind_n_oe |=> ind_n_o || !ind_n_oe)
        else $error("End of burst flag low for more than one clock");
    AST_IND_WITH_DQ: assert property (ind_n_oe |-> $past(!oe_n && !ce_n))
        else $error("End of burst flag driven without output enable");
    AST_ADV_PULSE: assert property ($fell(adv_n) |=> adv_n)
        else $error("Address valid held low past the start edge");
    AST_CMD_CYCLE: assert property (!we_n |-> (host_dq_oe && !dev_dq_oe) ##1 we_n)
        else $error("Command write cycle malformed");
    AST_CR_WR_BITS: assert property (!we_n && !ce_n && dq[31:24] == CMD_CR_WRITE |-> dq[6] && dq[5:3] == 3'h0)
        else $error("Register write with clock edge or reserved bits wrong");
endmodule : fbr_link_checker

/* File: dv/flash_burst_read_config_test.sv */
// Self-checking bench for the burst flash link driven through the controller registers
`timescale 1ns/1ps
module flash_burst_read_config_test;
    import fbr_pkg::*;
    localparam logic [15:0] DFLT = {1'b1, 1'b0, 4'h7, 1'b0, 1'b0, 1'b1, 1'b1, 3'h0, 3'h4};
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic algo_busy = 1'b0;
    logic [18:0] arr_rd_addr;
    logic [31:0] arr_rd_data;
    logic [15:0] cr_value;
    logic sync_mode;
    logic auto_sleep_en;
    logic bact;
    logic [31:0] ind_word;
    logic [31:0] q;
    logic [15:0] cfg;
    logic [18:0] a;
    int failures = 0;
    int cmp_count = 0;
    fbr_link_if link();
    always #20 core_clk = ~core_clk;
    // ----------------------------------------------------------------
    // Array model: distinct words, upper half nonzero
    // ----------------------------------------------------------------
    function automatic logic [31:0] aw(input logic [18:0] x);
        aw = {~x[15:0], x[18], x[14:0]};
    endfunction : aw
    assign arr_rd_data = aw(arr_rd_addr);
    always @(posedge core_clk) begin
        if (link.dev_dq_oe === 1'b1 && link.ind_n_o === 1'b0) begin
            ind_word <= link.dev_dq_o;
        end
    end
    fbr_flash_end fbr_flash_end_inst (.core_clk(core_clk), .reset_n(reset_n), .link(link), .algo_busy(algo_busy),
        .arr_rd_data(arr_rd_data), .arr_rd_addr(arr_rd_addr), .cr_value(cr_value), .sync_mode(sync_mode),
        .auto_sleep_en(auto_sleep_en), .burst_active(bact));
    fbr_ctrl_end fbr_ctrl_end_inst (.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .link(link));
    fbr_link_checker fbr_link_checker_inst (.core_clk(core_clk), .reset_n(reset_n), .ce_n(link.ce_n),
        .oe_n(link.oe_n), .we_n(link.we_n), .adv_n(link.adv_n), .rst_n(link.rst_n), .dq(link.dq),
        .host_dq_oe(link.host_dq_oe), .dev_dq_oe(link.dev_dq_oe), .ind_n_o(link.ind_n_o), .ind_n_oe(link.ind_n_oe));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Holds the request until waitrequest is sampled low
    task automatic acc(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= ad;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 40) begin
            failures++;
            tally_and_finish();
        end
    endtask : acc
    task automatic rd(input logic [7:0] ad, input logic [31:0] e, input string nm);
        acc(1'b0, ad, 32'h0000_0000);
        chk(nm, e, q);
    endtask : rd
    task automatic idle();
        int n;
        for (n = 0; n < 60; n++) begin
            acc(1'b0, REG_STATUS, 32'h0000_0000);
            if (q[0] === 1'b0) begin
                return;
            end
        end
        failures++;
        tally_and_finish();
    endtask : idle
    task automatic op(input logic [1:0] o, input logic [18:0] ad, input logic [31:0] d);
        acc(1'b1, REG_ADDR, {13'h0000, ad});
        acc(1'b1, REG_WDATA, d);
        acc(1'b1, REG_CTRL, {28'h000_0000, 1'b0, o, 1'b1});
        idle();
    endtask : op
    task automatic burst(input logic [18:0] ad, input logic [4:0] l, input logic [3:0] b);
        acc(1'b1, REG_LAT, {27'h000_0000, l});
        acc(1'b1, REG_BEATS, {28'h000_0000, b});
        ind_word = 32'h0000_0000;
        op(OP_READ, ad, 32'h0000_0000);
    endtask : burst
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        int k;
        int i;
        int n;
        logic [2:0] bl;
        logic wc;
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(REG_LAT, 32'h0000_0009, "lat_reset");
        rd(REG_BEATS, 32'h0000_0001, "beats_reset");
        rd(8'h18, 32'h0000_0000, "unmapped");
        a = 19'h0_0005;
        op(OP_WRITE, a, {CMD_CR_READ, 24'h00_0000});
        burst(a, 5'h03, 4'h2);
        rd(8'h20, {16'h0000, DFLT}, "cr_default");
        rd(8'h24, {16'h0000, DFLT}, "cr_held");
        burst(a | 19'h4_0000, 5'h03, 4'h1);
        rd(8'h20, aw(a | 19'h4_0000), "other_bank");
        algo_busy <= 1'b1;
        op(OP_WRITE, a, {CMD_CR_WRITE, 8'h00, 16'h0043});
        algo_busy <= 1'b0;
        chk("cr_busy", {16'h0000, DFLT}, {16'h0000, cr_value});
        // Length codes 2, 4, 8 with both flag timings; starts with low bits 1 to 6 (one per pass) show the wrap
        for (k = 0; k < 6; k++) begin
            bl = 3'(k / 2 + 1);
            wc = k[0];
            n = 1 << (k / 2 + 1);
            a = 19'(k * 9 + 1);
            cfg = {1'b0, wc, (k == 5) ? 4'h7 : 4'(k), 1'b0, wc, 1'b1, 1'b1, 3'h0, bl};
            op(OP_WRITE, a, {CMD_CR_WRITE, 8'h00, cfg});
            op(OP_WRITE, a, {CMD_READ_ARRAY, 24'h00_0000});
            chk("cr_value", {16'h0000, cfg}, {16'h0000, cr_value});
            chk("sleep", {31'h0000_0000, ~wc}, {31'h0000_0000, auto_sleep_en});
            chk("sync", 32'h0000_0001, {31'h0000_0000, sync_mode});
            burst(a, 5'(cfg[13:10]) + 5'h02, 4'h8);
            for (i = 0; i < 8; i++) begin
                rd({REG_RDATA_PAGE, 3'(i), 2'b00}, aw({a[18:3], (a[2:0] & 3'(~(n - 1))) | 3'((a[2:0] + i) & (n - 1))}),
                    "beat");
            end
            chk("ind_beat", aw({a[18:3], (a[2:0] & 3'(~(n - 1))) | 3'((a[2:0] + n - 1 - wc) & (n - 1))}),
                ind_word);
        end
        acc(1'b1, REG_CTRL, 32'h0000_0008);
        acc(1'b1, REG_CTRL, 32'h0000_0000);
        chk("cr_rst", {16'h0000, DFLT}, {16'h0000, cr_value});
        chk("rst_async", 32'h0000_0000, {31'h0000_0000, sync_mode});
        chk("burst_idle", 32'h0000_0000, {31'h0000_0000, bact});
        // Disabled length codes and read mode one: one word held, latency ignored
        for (k = 0; k < 5; k++) begin
            bl = (k == 4) ? 3'h3 : 3'((k == 0) ? 0 : k + 3);
            cfg = {1'(k == 4), 1'b0, 4'h7, 1'b0, 1'b0, 1'b1, 1'b1, 3'h0, bl};
            op(OP_WRITE, a, {CMD_CR_WRITE, 8'h00, cfg});
            op(OP_WRITE, a, {CMD_READ_ARRAY, 24'h00_0000});
            chk("async", 32'h0000_0000, {31'h0000_0000, sync_mode});
            burst(a, 5'h04, 4'h3);
            rd(8'h28, aw(a), "async_held");
        end
        tally_and_finish();
    end
endmodule : flash_burst_read_config_test
